/* verilog/sleep_wakeup_controller.sv */
`timescale 1ns/100ps
// How it works
// - Halt instruction enters power-down.
// - Entry clears watchdog, watchdog keeps counting.
// - Entry clears powerdown flag, sets timeout flag.
// - Main oscillator off, secondary oscillator untouched.
// - Ports hold pre-halt levels during power-down.
// - Watchdog reset never drives reset pin low.
// - External reset resets; others resume execution.
// - Powerdown flag and timeout flag both set at power-up.
// - Listed peripheral flags, plus the second-register flag, can wake.
// - Clocked first-register peripherals raise no flags asleep.
// - Halt prefetches instruction at PC plus one.
// - Individual enable wakes; global enable ignored.
// - Run next instruction, then vector if enabled.
// - Pending interrupt makes halt a no-operation.
// - Interrupt during halt: full halt, wake immediately.
// - Every wake clears the watchdog count.
module sleep_wakeup_controller
    import sleep_pkg::*;
#(
    parameter int PC_W = 13
)
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_halt_op,
    input wire logic i_watchdog_clear_op,
    input wire logic i_watchdog_en,
    input wire logic i_watchdog_expire,
    input wire logic [PC_W-1:0] i_pc,
    input wire irq_events_t i_events,
    input wire logic [7:0] i_wake_capable,
    input wire logic [7:0] i_port_out,
    input wire logic [7:0] i_port_oe,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_sleeping,
    output logic o_main_osc_en,
    output logic o_secondary_osc_en,
    output logic o_core_stall,
    output logic o_watchdog_clear,
    output logic o_watchdog_reset,
    output logic o_reset_pin_oe,
    output logic o_reset_pin_out,
    output logic [PC_W-1:0] o_fetch_pc,
    output logic o_fetch_valid,
    output logic o_vector_take,
    output logic [PC_W-1:0] o_vector_pc,
    output logic [7:0] o_port_out,
    output logic [7:0] o_port_oe,
    output logic o_powerdown_flag,
    output logic o_timeout_flag
);

    pwr_state_t state_q;
    logic [7:0] pin_change_enable_q;
    logic [7:0] interrupt_control_q;
    logic [7:0] peripheral_irq_enable_one_q;
    logic [7:0] peripheral_irq_enable_two_q;
    logic [7:0] peripheral_irq_flags_one_q;
    logic [7:0] peripheral_irq_flags_two_q;
    logic powerdown_flag_q;
    logic timeout_flag_q;
    logic [7:0] port_out_q;
    logic [7:0] port_oe_q;
    logic [PC_W-1:0] fetch_pc_q;
    logic fetch_valid_q;
    logic vector_q;
    logic wd_clear_q;
    logic [7:0] rdata_q;
    logic pending;
    logic halt_take;
    logic halt_nop;
    logic wd_wake;
    logic [7:0] live_one;
    logic [7:0] live_two;

    // Flags may only rise asleep from sources that keep running there.
    function automatic logic [7:0] gate_sleep(input logic [7:0] ev,
                                              input logic [7:0] ok,
                                              input logic asleep);
        gate_sleep = asleep ? (ev & ok) : ev;
    endfunction

    // Any flag whose individual enable is set; the global enable is not
    // part of the term, so wake does not depend on it.
    always_comb
    begin
        live_one = gate_sleep(i_events.pir_one,
                              i_wake_capable & WAKE_PIR_ONE,
                              state_q == ST_SLEEP);
        live_two = i_events.pir_two & PIE_TWO_MASK;
        pending = |(peripheral_irq_flags_one_q & peripheral_irq_enable_one_q)
            | |(peripheral_irq_flags_two_q & peripheral_irq_enable_two_q)
            | (interrupt_control_q[INTF_BIT] & interrupt_control_q[INTE_BIT])
            | (interrupt_control_q[RBIF_BIT]
               & interrupt_control_q[RBIE_BIT]);
        halt_take = (state_q == ST_RUN) && i_halt_op && !pending;
        halt_nop = (state_q == ST_RUN) && i_halt_op && pending;
        wd_wake = (state_q == ST_SLEEP) && i_watchdog_en
            && i_watchdog_expire;
    end

    // Power state. A wake lasts one cycle in ST_WAKE so the prefetched
    // instruction runs before any vector is taken.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            state_q <= ST_RUN;
        else
        begin
            case (state_q)
                ST_RUN:
                    if (halt_take)
                        state_q <= ST_SLEEP;
                ST_SLEEP:
                    if (pending || wd_wake)
                        state_q <= ST_WAKE;
                ST_WAKE:
                    state_q <= ST_RUN;
                default:
                    state_q <= ST_RUN;
            endcase
        end
    end

    // Status flags: power-up sets powerdown; a real halt clears it and
    // sets timeout; a watchdog wake clears timeout. A halt taken as a
    // no-operation touches neither.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            powerdown_flag_q <= 1'b1;
            timeout_flag_q <= 1'b1;
        end
        else if (halt_take)
        begin
            powerdown_flag_q <= 1'b0;
            timeout_flag_q <= 1'b1;
        end
        else if (wd_wake)
            timeout_flag_q <= 1'b0;
        else if (i_watchdog_clear_op && state_q == ST_RUN)
        begin
            powerdown_flag_q <= 1'b1;
            timeout_flag_q <= 1'b1;
        end
    end

    // Watchdog clear pulse on real entry, on every wake and on the
    // clear instruction; the watchdog itself keeps counting asleep.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            wd_clear_q <= 1'b0;
        else
            wd_clear_q <= halt_take
                || (state_q == ST_SLEEP && (pending || wd_wake))
                || (i_watchdog_clear_op && state_q == ST_RUN && !halt_nop);
    end

    // Port levels captured at the halt and held while asleep.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            port_out_q <= RST_BYTE;
            port_oe_q <= RST_BYTE;
        end
        else if (state_q == ST_RUN && !halt_take)
        begin
            port_out_q <= i_port_out;
            port_oe_q <= i_port_oe;
        end
        else if (halt_take)
        begin
            port_out_q <= i_port_out;
            port_oe_q <= i_port_oe;
        end
    end

    // Prefetch of the instruction after the halt, and the vector
    // request one cycle after the wake when the global enable is set.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            fetch_pc_q <= '0;
            fetch_valid_q <= 1'b0;
            vector_q <= 1'b0;
        end
        else
        begin
            fetch_valid_q <= halt_take;
            if (halt_take)
                fetch_pc_q <= i_pc + PC_W'(1);
            vector_q <= (state_q == ST_WAKE)
                && interrupt_control_q[GLOBAL_EN_BIT] && pending;
        end
    end

    // Software registers. Hardware setting a flag wins over a clear
    // written in the same cycle.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pin_change_enable_q <= RST_BYTE;
            interrupt_control_q <= RST_BYTE;
            peripheral_irq_enable_one_q <= RST_BYTE;
            peripheral_irq_enable_two_q <= RST_BYTE;
            peripheral_irq_flags_one_q <= RST_BYTE;
            peripheral_irq_flags_two_q <= RST_BYTE;
        end
        else
        begin
            if (i_wr)
            begin
                case (i_addr)
                    ADDR_PIN_CHANGE: pin_change_enable_q <= i_wdata;
                    ADDR_INTCTL: interrupt_control_q <= i_wdata;
                    ADDR_PIE_ONE: peripheral_irq_enable_one_q <= i_wdata;
                    ADDR_PIE_TWO:
                        peripheral_irq_enable_two_q <= i_wdata & PIE_TWO_MASK;
                    ADDR_PIR_ONE: peripheral_irq_flags_one_q <= i_wdata;
                    ADDR_PIR_TWO:
                        peripheral_irq_flags_two_q <= i_wdata & PIE_TWO_MASK;
                    default: ;
                endcase
            end
            if (i_events.ext_pin)
                interrupt_control_q[INTF_BIT] <= 1'b1;
            if (i_events.pin_change)
                interrupt_control_q[RBIF_BIT] <= 1'b1;
            peripheral_irq_flags_one_q <= ((i_wr && i_addr == ADDR_PIR_ONE)
                ? i_wdata : peripheral_irq_flags_one_q) | live_one;
            peripheral_irq_flags_two_q <= ((i_wr && i_addr == ADDR_PIR_TWO)
                ? (i_wdata & PIE_TWO_MASK) : peripheral_irq_flags_two_q)
                | live_two;
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read 0.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rdata_q <= RST_BYTE;
        else if (i_rd)
        begin
            case (i_addr)
                ADDR_PIN_CHANGE: rdata_q <= pin_change_enable_q;
                ADDR_INTCTL: rdata_q <= interrupt_control_q;
                ADDR_PIE_ONE: rdata_q <= peripheral_irq_enable_one_q;
                ADDR_PIE_TWO: rdata_q <= peripheral_irq_enable_two_q;
                ADDR_PIR_ONE: rdata_q <= peripheral_irq_flags_one_q;
                ADDR_PIR_TWO: rdata_q <= peripheral_irq_flags_two_q;
                ADDR_STATUS:
                    rdata_q <= {5'h00, state_q == ST_SLEEP,
                                timeout_flag_q, powerdown_flag_q};
                default: rdata_q <= RST_BYTE;
            endcase
        end
        else
            rdata_q <= RST_BYTE;
    end

    // Outputs. The watchdog reset goes to the core only; the reset pin
    // is never driven, so an expiry cannot pull it low.
    assign o_rdata = rdata_q;
    assign o_sleeping = state_q == ST_SLEEP;
    assign o_main_osc_en = state_q != ST_SLEEP;
    assign o_secondary_osc_en = 1'b1;
    assign o_core_stall = state_q == ST_SLEEP;
    assign o_watchdog_clear = wd_clear_q;
    assign o_watchdog_reset = i_watchdog_en && i_watchdog_expire
        && state_q != ST_SLEEP;
    assign o_reset_pin_oe = 1'b0;
    assign o_reset_pin_out = 1'b0;
    assign o_fetch_pc = fetch_pc_q;
    assign o_fetch_valid = fetch_valid_q;
    assign o_vector_take = vector_q;
    assign o_vector_pc = IRQ_VECTOR[PC_W-1:0];
    assign o_port_out = port_out_q;
    assign o_port_oe = port_oe_q;
    assign o_powerdown_flag = powerdown_flag_q;
    assign o_timeout_flag = timeout_flag_q;

    property p_enter;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        halt_take |=> (state_q == ST_SLEEP) && !powerdown_flag_q
            && timeout_flag_q && wd_clear_q;
    endproperty
    a_enter: assert property (p_enter) else $error("bad entry");

    property p_nop;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        halt_nop |=> $stable(powerdown_flag_q) && state_q == ST_RUN;
    endproperty
    a_nop: assert property (p_nop) else $error("halt not a nop");

    property p_osc;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_sleeping |-> !o_main_osc_en && o_secondary_osc_en;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator wrong");

    property p_ports;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_sleeping && $past(o_sleeping) |-> $stable(o_port_out)
            && $stable(o_port_oe);
    endproperty
    a_ports: assert property (p_ports) else $error("ports moved");

    property p_pin;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        i_watchdog_expire |-> !o_reset_pin_oe;
    endproperty
    a_pin: assert property (p_pin) else $error("reset pin driven");

    property p_wake;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (state_q == ST_SLEEP) && pending |=> state_q == ST_WAKE
            ##1 state_q == ST_RUN;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");

    property p_wdwake;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        wd_wake |=> !timeout_flag_q && wd_clear_q;
    endproperty
    a_wdwake: assert property (p_wdwake) else $error("wd wake");

    property p_prefetch;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        halt_take |=> o_fetch_valid && o_fetch_pc == $past(i_pc) + 1'b1;
    endproperty
    a_prefetch: assert property (p_prefetch) else $error("prefetch");

    property p_stay;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (state_q == ST_SLEEP) && !pending && !wd_wake |=> o_core_stall;
    endproperty
    a_stay: assert property (p_stay) else $error("left sleep");

endmodule

/* verilog/sleep_pkg.sv */
package sleep_pkg;

    // Register indices on the plain register port.
    localparam logic [2:0] ADDR_PIN_CHANGE = 3'h0;
    localparam logic [2:0] ADDR_INTCTL = 3'h1;
    localparam logic [2:0] ADDR_PIE_ONE = 3'h2;
    localparam logic [2:0] ADDR_PIE_TWO = 3'h3;
    localparam logic [2:0] ADDR_PIR_ONE = 3'h4;
    localparam logic [2:0] ADDR_PIR_TWO = 3'h5;
    localparam logic [2:0] ADDR_STATUS = 3'h6;

    // Reset value and the second-register enable/flag mask.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] PIE_TWO_MASK = 8'h01;

    // Interrupt control field positions.
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PEIE_BIT = 6;
    localparam int INTE_BIT = 4;
    localparam int RBIE_BIT = 3;
    localparam int INTF_BIT = 1;
    localparam int RBIF_BIT = 0;

    // Status byte field positions.
    localparam int STAT_POWERDOWN_BIT = 0;
    localparam int STAT_TIMEOUT_BIT = 1;
    localparam int STAT_SLEEP_BIT = 2;

    // Peripheral flags that may wake the core from power-down:
    // conversion, receive, serial port, capture channel a, timer1.
    // The gate flag and the second timer need on-chip clocks.
    localparam logic [7:0] WAKE_PIR_ONE = 8'h6D;

    // Interrupt vector used after a wake with the global enable set.
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;

    typedef struct packed {
        logic [7:0] pir_one;
        logic [7:0] pir_two;
        logic ext_pin;
        logic pin_change;
    } irq_events_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_SLEEP = 3'h2,
        ST_WAKE = 3'h4
    } pwr_state_t;

endpackage

/* tb/core_model.sv */
`timescale 1ns/100ps
module core_model
    import sleep_pkg::*;
(
    input wire logic i_sys_clk,
    output logic o_halt_op,
    output logic o_wdc_op,
    output logic [12:0] o_pc,
    output irq_events_t o_events
);
    // The core starts idle, with no operation and no flag pulse.
    initial
    begin
        o_halt_op = 1'b0;
        o_wdc_op = 1'b0;
        o_pc = 13'h0000;
        o_events = '0;
    end

    // Halt, optionally after a watchdog clear; only no-ops follow it.
    task automatic halt(input logic [12:0] pc, input logic clr);
        if (clr)
        begin
            @(posedge i_sys_clk);
            o_wdc_op <= 1'b1;
        end
        @(posedge i_sys_clk);
        o_wdc_op <= 1'b0;
        o_halt_op <= 1'b1;
        o_pc <= pc;
        @(posedge i_sys_clk);
        o_halt_op <= 1'b0;
    endtask

    // Sources raise their flags as a one-cycle set pulse.
    task automatic fire(input irq_events_t ev);
        @(posedge i_sys_clk);
        o_events <= ev;
        @(posedge i_sys_clk);
        o_events <= '0;
    endtask
endmodule

/* tb/sleep_wakeup_controller_tb_top.sv */
`timescale 1ns/100ps
module sleep_wakeup_controller_tb_top;
    import sleep_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wd_en = 1'b0;
    logic wd_exp = 1'b0;
    logic [7:0] cap = 8'hFF;
    logic [7:0] pout = 8'hA5;
    logic [7:0] poe = 8'h0F;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic halt, wdc_op, slp, mosc, sosc, stall, wclr, wrst;
    logic rpoe, rpout, fvalid, vtake, dnf, tmf;
    logic [12:0] pc, fetch_pc, vec_pc;
    logic [7:0] rdata, o_pout, o_poe;
    irq_events_t ev;
    int n_fail = 0;
    int num_checks = 0;
    int n_clr = 0;
    int n_vec = 0;
    int c0, v0;

    // Free-running 20 MHz system clock.
    always #25 clk = ~clk;

    core_model core (.i_sys_clk(clk), .o_halt_op(halt), .o_wdc_op(wdc_op),
        .o_pc(pc), .o_events(ev));

    sleep_wakeup_controller #(.PC_W(13)) uut (.i_sys_clk(clk),
        .i_arst_n(rst_n), .i_halt_op(halt), .i_watchdog_clear_op(wdc_op),
        .i_watchdog_en(wd_en), .i_watchdog_expire(wd_exp), .i_pc(pc),
        .i_events(ev), .i_wake_capable(cap), .i_port_out(pout),
        .i_port_oe(poe), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
        .i_rd(rd_s), .o_rdata(rdata), .o_sleeping(slp),
        .o_main_osc_en(mosc), .o_secondary_osc_en(sosc),
        .o_core_stall(stall), .o_watchdog_clear(wclr),
        .o_watchdog_reset(wrst), .o_reset_pin_oe(rpoe),
        .o_reset_pin_out(rpout), .o_fetch_pc(fetch_pc),
        .o_fetch_valid(fvalid), .o_vector_take(vtake),
        .o_vector_pc(vec_pc), .o_port_out(o_pout), .o_port_oe(o_poe),
        .o_powerdown_flag(dnf), .o_timeout_flag(tmf));

    // Pulses are counted so a missed or doubled one shows up later.
    always @(posedge clk)
    begin
        if (wclr === 1'b1)
            n_clr++;
        if (vtake === 1'b1)
            n_vec++;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(16'(rdata), 16'(exp));
    endtask

    // A hang here is a failure; the bound keeps the run finite.
    task automatic wait_slp(input logic exp);
        for (int i = 0; i < 20; i++)
        begin
            if (slp === exp)
                return;
            @(posedge clk);
            #1;
        end
        n_fail++;
        $display("unexpected at %0t: got %0h exp %0h", $time, slp, exp);
        final_report;
    endtask

    task automatic t_reset;
        reg_rd(ADDR_STATUS, 8'h03);
        for (int a = 0; a < 6; a++)
            reg_rd(3'(a), RST_BYTE);
        reg_rd(3'h7, 8'h00);
        chk(16'({mosc, sosc, slp, rpoe}), 16'h000C);
    endtask

    task automatic t_nop;
        reg_wr(ADDR_INTCTL, 8'h10);
        core.fire({16'h0000, 2'b10});
        c0 = n_clr;
        core.halt(13'h0050, 1'b0);
        repeat (3) @(posedge clk);
        #1;
        chk(16'({slp, dnf, tmf}), 16'h0003);
        chk(16'(n_clr - c0), 16'h0000);
        reg_wr(ADDR_INTCTL, 8'h00);
    endtask

    task automatic t_sleep;
        reg_wr(ADDR_PIE_ONE, 8'h03);
        cap <= 8'hFE;
        c0 = n_clr;
        v0 = n_vec;
        core.halt(13'h0123, 1'b0);
        #1;
        chk(16'({slp, stall, fvalid, dnf, tmf}), 16'h001D);
        chk(16'(fetch_pc), 16'h0124);
        chk(16'({mosc, sosc}), 16'h0001);
        pout <= 8'h3C;
        poe <= 8'hF0;
        // Timer2 is never a wake source; timer1 is not yet capable.
        core.fire({8'h03, 8'h00, 2'b00});
        repeat (10) @(posedge clk);
        #1;
        chk(16'({o_pout, o_poe}), 16'hA50F);
        chk(16'(slp), 16'h0001);
        // Same pulse again; only the now capable timer1 may set its flag.
        cap <= 8'hFF;
        core.fire({8'h03, 8'h00, 2'b00});
        wait_slp(1'b0);
        repeat (3) @(posedge clk);
        #1;
        chk(16'(n_clr - c0), 16'h0002);
        chk(16'(n_vec - v0), 16'h0000);
        chk(16'({o_pout, mosc}), 16'h0079);
        reg_rd(ADDR_PIR_ONE, 8'h01);
        reg_wr(ADDR_PIR_ONE, 8'h00);
    endtask

    // Pin change lands in the very cycle of the halt.
    task automatic t_vector;
        reg_wr(ADDR_INTCTL, 8'h88);
        c0 = n_clr;
        v0 = n_vec;
        fork
            core.halt(13'h0200, 1'b0);
            core.fire({16'h0000, 2'b01});
        join
        #1;
        chk(16'(slp), 16'h0001);
        wait_slp(1'b0);
        repeat (3) @(posedge clk);
        #1;
        chk(16'(n_vec - v0), 16'h0001);
        chk(16'(vec_pc), 16'(IRQ_VECTOR));
        chk(16'(n_clr - c0), 16'h0002);
        chk(16'({dnf, tmf}), 16'h0001);
        reg_wr(ADDR_INTCTL, 8'h00);
    endtask

    task automatic t_watchdog;
        wd_en <= 1'b1;
        @(posedge clk);
        wd_exp <= 1'b1;
        // The reset request is combinational; look while expiry stands.
        #1;
        chk(16'({wrst, rpoe, rpout}), 16'h0004);
        @(posedge clk);
        wd_exp <= 1'b0;
        core.halt(13'h0300, 1'b1);
        wait_slp(1'b1);
        @(posedge clk);
        wd_exp <= 1'b1;
        #1;
        chk(16'({wrst, rpoe}), 16'h0000);
        @(posedge clk);
        wd_exp <= 1'b0;
        wait_slp(1'b0);
        reg_rd(ADDR_STATUS, 8'h00);
        wd_en <= 1'b0;
    endtask

    task automatic t_ext_reset;
        core.halt(13'h0400, 1'b0);
        wait_slp(1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        chk(16'({slp, dnf, tmf, mosc}), 16'h0007);
        @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(ADDR_STATUS, 8'h03);
    endtask

    // Reset for 12 cycles; t_ext_reset later pulls the reset pin low while asleep.
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_nop;
        t_sleep;
        t_vector;
        t_watchdog;
        t_ext_reset;
        final_report;
    end
endmodule
